// ---- logic/drss_host.sv ----
// Overview of operation
// - System supplies a pull-up on rail-1 good.
// - Unused manual reset inputs are driven high, not left floating.
// - Reset is open-drain active low; system supplies its pull-up.
// - Rail-1 good may be routed to a manual reset input.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module drss_host
  import drss_pkg::*;
#(
  parameter int unsigned RST_TMO_CYC = DRSS_RST_TMO_CYC
)(
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_irq,
  output logic             o_enable_n,
  output logic             o_order_select,
  output logic             o_manual_reset_a_n,
  output logic             o_manual_reset_b_n,
  input  wire logic        i_reset_n,
  input  wire logic        i_rail1_good
);

  drss_ctrl_t                 ctrl_q;
  logic [DRSS_EVT_W-1:0]      mask_q;
  logic [DRSS_EVT_W-1:0]      stat_q;
  logic [DRSS_SYNC_W-1:0]     pin_raw;
  logic [DRSS_SYNC_W-1:0]     pin_s;
  logic                       rst_s_q;
  logic                       pg_s_q;
  logic [DRSS_TMO_CNT_W-1:0]  tmo_cnt_q;
  logic                       tmo_done_q;
  drss_evt_t                  evt;
  logic                       rd_stat;
  logic                       waiting;
  logic [DRSS_TMO_CNT_W-1:0]  tmo_lim;

  // ==========================================================
  // Pin synchronisers
  // Pulled-up reset pin
  assign pin_raw[DRSS_SYNC_RST] = i_reset_n;
  assign pin_raw[DRSS_SYNC_PG]  = i_rail1_good;

  drss_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_async   (pin_raw),
    .o_sync    (pin_s)
  );

  // Edge flops idle high like the pins
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s_q <= 1'b1;
      pg_s_q  <= 1'b1;
    end else begin
      rst_s_q <= pin_s[DRSS_SYNC_RST];
      pg_s_q  <= pin_s[DRSS_SYNC_PG];
    end
  end

  // ==========================================================
  // Control and interrupt mask registers
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= DRSS_CTRL_RST;
    end else if (i_wr && i_addr == DRSS_ADDR_CTRL) begin
      ctrl_q <= drss_ctrl_t'(i_wdata[DRSS_CTRL_W-1:0]);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mask_q <= DRSS_MASK_RST;
    end else if (i_wr && i_addr == DRSS_ADDR_IRQ_MASK) begin
      mask_q <= i_wdata[DRSS_EVT_W-1:0];
    end
  end

  // ==========================================================
  // Device pins
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_enable_n         <= 1'b1;
      o_order_select     <= 1'b1;
      o_manual_reset_a_n <= 1'b1;
      o_manual_reset_b_n <= 1'b1;
    end else begin
      o_enable_n         <= ~ctrl_q.enable;
      o_order_select     <= ctrl_q.order_sel;
      o_manual_reset_a_n <= ~ctrl_q.mr_a;
      o_manual_reset_b_n <= ~(ctrl_q.mr_b |
                              (ctrl_q.link_pg & ~pin_s[DRSS_SYNC_PG]));
    end
  end

  // ==========================================================
  // Reset release watchdog
  assign tmo_lim = RST_TMO_CYC[DRSS_TMO_CNT_W-1:0];
  assign waiting = ctrl_q.enable & o_manual_reset_a_n &
                   o_manual_reset_b_n & ~pin_s[DRSS_SYNC_RST];

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmo_cnt_q  <= '0;
      tmo_done_q <= 1'b0;
    end else if (!waiting) begin
      tmo_cnt_q  <= '0;
      tmo_done_q <= 1'b0;
    end else if (tmo_cnt_q != tmo_lim) begin
      tmo_cnt_q  <= tmo_cnt_q + 1'b1;
    end else begin
      tmo_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // Events and interrupt
  always_comb begin
    evt.rst_rise = pin_s[DRSS_SYNC_RST] & ~rst_s_q;
    evt.rst_fall = ~pin_s[DRSS_SYNC_RST] & rst_s_q;
    evt.pg_rise  = pin_s[DRSS_SYNC_PG] & ~pg_s_q;
    evt.pg_fall  = ~pin_s[DRSS_SYNC_PG] & pg_s_q;
    evt.timeout  = waiting & (tmo_cnt_q == tmo_lim) & ~tmo_done_q;
  end

  assign rd_stat = i_rd && i_addr == DRSS_ADDR_IRQ_STAT;

  // Set wins over read clear
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (rd_stat ? '0 : stat_q) | evt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((rd_stat ? '0 : stat_q) | evt) & mask_q);
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        DRSS_ADDR_CTRL:
          o_rdata <= {{(32-DRSS_CTRL_W){1'b0}}, ctrl_q};
        DRSS_ADDR_STATUS:
          o_rdata <= {{(32-DRSS_STAT_W){1'b0}}, tmo_done_q, waiting,
                      pin_s[DRSS_SYNC_PG], pin_s[DRSS_SYNC_RST]};
        DRSS_ADDR_IRQ_STAT:
          o_rdata <= {{(32-DRSS_EVT_W){1'b0}}, stat_q};
        DRSS_ADDR_IRQ_MASK:
          o_rdata <= {{(32-DRSS_EVT_W){1'b0}}, mask_q};
        default:
          o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : drss_host

// ---- logic/drss_sync.sv ----
`timescale 1ns/10ps
module drss_sync
  import drss_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_arst_n,
  input  wire logic [DRSS_SYNC_W-1:0] i_async,
  output logic      [DRSS_SYNC_W-1:0] o_sync
);

  logic [DRSS_SYNC_W-1:0] meta_q;

  // ==========================================================
  // Two-stage synchronisers, pulled-up pins idle high
  for (genvar g = 0; g < DRSS_SYNC_W; g++) begin : g_sync
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        meta_q[g] <= 1'b1;
        o_sync[g] <= 1'b1;
      end else begin
        meta_q[g] <= i_async[g];
        o_sync[g] <= meta_q[g];
      end
    end
  end

endmodule : drss_sync

// ---- shared/drss_pkg.sv ----
package drss_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] DRSS_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] DRSS_ADDR_STATUS   = 8'h04;
  localparam logic [7:0] DRSS_ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] DRSS_ADDR_IRQ_MASK = 8'h0C;

  // ==========================================================
  // Field layout
  localparam int DRSS_CTRL_W   = 5;
  localparam int DRSS_STAT_W   = 4;
  localparam int DRSS_EVT_W    = 5;
  localparam int DRSS_SYNC_W   = 2;
  localparam int DRSS_SYNC_RST = 0;
  localparam int DRSS_SYNC_PG  = 1;

  typedef struct packed {
    logic link_pg;
    logic mr_b;
    logic mr_a;
    logic order_sel;
    logic enable;
  } drss_ctrl_t;

  typedef struct packed {
    logic timeout;
    logic pg_fall;
    logic pg_rise;
    logic rst_fall;
    logic rst_rise;
  } drss_evt_t;

  localparam drss_ctrl_t DRSS_CTRL_RST = '{
    link_pg: 1'b0, mr_b: 1'b0, mr_a: 1'b0, order_sel: 1'b1, enable: 1'b0};
  localparam logic [DRSS_EVT_W-1:0] DRSS_MASK_RST = 5'h00;

  // ==========================================================
  // Timing
  localparam int unsigned DRSS_CLK_MHZ     = 100;
  localparam int unsigned DRSS_RST_TMO_MS  = 160;
  localparam int unsigned DRSS_RST_TMO_CYC =
    DRSS_RST_TMO_MS * 1000 * DRSS_CLK_MHZ;
  localparam int DRSS_TMO_CNT_W = 24;

endpackage : drss_pkg

// ---- verif/drss_assertions.sv ----
`timescale 1ns/10ps
module drss_assertions
  import drss_pkg::*;
#(
  parameter int unsigned RST_TMO_CYC = DRSS_RST_TMO_CYC
)(
  input wire logic        i_clk_sys,
  input wire logic        i_arst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq,
  input wire logic        o_enable_n,
  input wire logic        o_order_select,
  input wire logic        o_manual_reset_a_n,
  input wire logic        o_manual_reset_b_n,
  input wire logic        i_reset_n,
  input wire logic        i_rail1_good
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  sequence s_wr;
    i_wr && i_addr == DRSS_ADDR_CTRL ##1 1'h1;
  endsequence
  sequence s_pins;
    $stable({i_reset_n, i_rail1_good})[*3];
  endsequence
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata");
  a_enable_pin:
    assert property (s_wr |=> o_enable_n == !$past(i_wdata[0], 2))
    else $error("enable pin");
  a_order_pin:
    assert property (s_wr |=> o_order_select == $past(i_wdata[1], 2))
    else $error("order pin");
  a_reset_a_pin:
    assert property (s_wr |=> o_manual_reset_a_n == !$past(i_wdata[2], 2))
    else $error("reset a pin");
  a_reset_b_pin:
    assert property (s_wr |=> !$past(i_wdata[3], 2) || !o_manual_reset_b_n)
    else $error("reset b pin");
  a_pins_hold:
    assert property (!$past(i_wr, 2) |-> $stable(o_enable_n))
    else $error("enable moved");
  a_link_good:
    assert property (i_wr && i_addr == DRSS_ADDR_CTRL && i_wdata[4:3] == 2'h2
      ##1 (!i_wr && !i_rail1_good)[*4] |=> !o_manual_reset_b_n)
    else $error("link");
  a_status_pins:
    assert property (s_pins ##0 i_rd && i_addr == DRSS_ADDR_STATUS |=>
      o_rdata[1:0] == $past({i_rail1_good, i_reset_n})) else $error("stat");
endmodule : drss_assertions
bind drss_host drss_assertions #(.RST_TMO_CYC(RST_TMO_CYC)) chk_u (.*);

// ---- verif/drss_dev_model.sv ----
`timescale 1ns/10ps
module drss_dev_model #(
  parameter int DLY = 30
)(
  input  wire logic i_clk_sys,
  input  wire logic i_enable_n,
  input  wire logic i_order_select,
  input  wire logic i_manual_reset_a_n,
  input  wire logic i_manual_reset_b_n,
  input  wire logic i_overload,
  output logic      o_reset_n,
  output logic      o_rail1_good
);
  logic r1_q  = 1'h0;
  logic r2_q  = 1'h0;
  logic rst_q = 1'h0;
  int   cnt_q = 0;
  // ==========================================================
  // Rails
  // sequencing order
  always_ff @(posedge i_clk_sys) begin
    r2_q <= !i_enable_n && !i_overload && (i_order_select || r1_q);
    r1_q <= !i_enable_n && (!i_order_select || r2_q);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_enable_n || !i_manual_reset_a_n || !i_manual_reset_b_n || !r2_q) begin
      cnt_q <= 0;
      rst_q <= 1'h0;
    end else if (cnt_q == DLY) rst_q <= 1'h1;
    else cnt_q <= cnt_q + 1;
  end
  assign o_rail1_good = r1_q;
  assign o_reset_n    = rst_q;
endmodule : drss_dev_model

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb
  import drss_pkg::*;
;
  localparam int TMO = 50;
  logic        clk = 1'h0, arst_n = 1'h0, wr = 1'h0, rd = 1'h0, ovl = 1'h0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0, lf = 32'h45A0, rdata, rv;
  logic        irq, en_n, ord, ma_n, mb_n, rst_n, pg;
  int          fails = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  drss_host #(.RST_TMO_CYC(TMO)) dut_u (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_irq(irq), .o_enable_n(en_n), .o_order_select(ord),
    .o_manual_reset_a_n(ma_n), .o_manual_reset_b_n(mb_n),
    .i_reset_n(rst_n), .i_rail1_good(pg));
  drss_dev_model #(.DLY(30)) dev_u (.i_clk_sys(clk), .i_enable_n(en_n),
    .i_order_select(ord), .i_manual_reset_a_n(ma_n),
    .i_manual_reset_b_n(mb_n), .i_overload(ovl), .o_reset_n(rst_n),
    .o_rail1_good(pg));
  // ==========================================================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [31:0] stat_exp(input logic tmo, input logic wt,
                                           input logic pg1, input logic rs);
    return {28'h0, tmo, wt, pg1, rs};
  endfunction : stat_exp
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d = 32'h0);
    @(posedge clk);
    wr    <= w;
    rd    <= !w;
    addr  <= a;
    wdata <= {lf[31:5], d[4:0]};
    lf = lfsr(lf);
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    @(negedge clk);
    rv = rdata;
  endtask : bus
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wait_rst(input logic lvl);
    n = 0;
    do begin
      bus(1'h0, DRSS_ADDR_STATUS);
      n++;
    end while (rv[0] !== lvl && n < 100);
    if (rv[0] !== lvl) cmp({31'h0, rv[0]}, {31'h0, lvl});
  endtask : wait_rst
  task automatic test_done;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // ==========================================================
  // Tests
  initial begin
    #100000;
    fails++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    bus(1'h0, DRSS_ADDR_CTRL);
    cmp(rv, 32'h2);
    bus(1'h0, 8'h10);
    cmp(rv, 32'h0);
    bus(1'h0, DRSS_ADDR_IRQ_STAT);
    bus(1'h1, DRSS_ADDR_IRQ_MASK, 32'h1F);
    for (int i = 0; i < 2; i++) begin
      bus(1'h1, DRSS_ADDR_CTRL, {31'h0, !i[0]} << 1 | 32'h1);
      wait_rst(1'h1);
      cmp(rv, stat_exp(1'h0, 1'h0, 1'h1, 1'h1));
      cmp({31'h0, irq}, 32'h1);
      bus(1'h0, DRSS_ADDR_IRQ_STAT);
      cmp(rv, 32'h5);
      bus(1'h1, DRSS_ADDR_CTRL, {1'h0, i[0], !i[0], !i[0]} << 1 | 32'h1);
      wait_rst(1'h0);
      cmp(rv, stat_exp(1'h0, 1'h0, 1'h1, 1'h0));
      bus(1'h1, DRSS_ADDR_CTRL, {31'h0, !i[0]} << 1 | 32'h1);
      wait_rst(1'h1);
      cmp(rv, stat_exp(1'h0, 1'h0, 1'h1, 1'h1));
      bus(1'h1, DRSS_ADDR_CTRL, 32'h0);
      wait_rst(1'h0);
      cmp(rv, stat_exp(1'h0, 1'h0, 1'h0, 1'h0));
      bus(1'h0, DRSS_ADDR_IRQ_STAT);
      $display("test order %0d done", !i[0]);
    end
    @(posedge clk) ovl <= 1'h1;
    bus(1'h1, DRSS_ADDR_IRQ_MASK, 32'hB);
    bus(1'h1, DRSS_ADDR_CTRL, 32'h1);
    repeat (TMO + 20) @(posedge clk);
    bus(1'h0, DRSS_ADDR_STATUS);
    cmp(rv, stat_exp(1'h1, 1'h1, 1'h1, 1'h0));
    cmp({31'h0, irq}, 32'h0);
    bus(1'h0, DRSS_ADDR_IRQ_STAT);
    cmp(rv, 32'h14);
    $display("test timeout done");
    bus(1'h1, DRSS_ADDR_CTRL, 32'h2);
    bus(1'h1, DRSS_ADDR_CTRL, 32'h13);
    repeat (10) @(posedge clk);
    @(negedge clk);
    cmp({31'h0, mb_n}, 32'h0);
    @(posedge clk) ovl <= 1'h0;
    wait_rst(1'h1);
    cmp(rv, stat_exp(1'h0, 1'h0, 1'h1, 1'h1));
    @(posedge clk) ovl <= 1'h1;
    wait_rst(1'h0);
    bus(1'h0, DRSS_ADDR_STATUS);
    cmp(rv, stat_exp(1'h0, 1'h0, 1'h0, 1'h0));
    $display("test link done");
    test_done();
  end
endmodule : tb
